// ==== hdl/ipm_meter.sv ====
// Input power meter for one channel: continuous and triggered averaging.
// Assumes samples arrive on ref_clk from same-domain logic with valid/ready,
// and that the result consumer may stall through res_ready.
//
// Contract
// RULE_01: One independent meter per channel; instantiate this module per channel.
// RULE_02: Two selectable modes, continuous averaging and triggered averaging.
// RULE_03: Samples taken at the 78 MHz sample rate; all decisions per sample.
// RULE_04: Continuous mode uses every sample, producing results repeatedly; code skips samples during window fill and up to two per result.
// RULE_05: Continuous count counts 16-sample blocks; sum count times 16 powers.
// RULE_06: Trigger accepts sample if previous-eight and next-eight means exceed level.
// RULE_07: Triggered count counts accepted samples only, across bursts and gaps.
// RULE_08: Isolated high samples excluded unless both window means exceed level.
// RULE_09: Delay samples eight periods; output sum over total with valid strobe.
`timescale 1ns/1ps
`include "ipm_params.svh"
module ipm_meter #(
  parameter int SAMPLE_W = `IPM_SAMPLE_W,
  parameter int COUNT_W = `IPM_COUNT_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire ipm_pkg::ipm_mode_t mode,
  input wire logic enable,
  input wire logic [COUNT_W-1:0] avg_count,
  input wire logic [`IPM_POWER_W-1:0] trig_level,
  input wire logic signed [SAMPLE_W-1:0] in_i,
  input wire logic signed [SAMPLE_W-1:0] in_q,
  input wire logic in_valid,
  output logic in_ready,
  output logic [`IPM_POWER_W-1:0] res_power,
  output logic res_valid,
  input wire logic res_ready,
  output logic res_strobe,
  output logic busy
);
  import ipm_pkg::*;

  // One meter per channel: no state here is shared with another channel [RULE_01]
  // A multi-channel device places one instance of this module per input

  localparam int PW = `IPM_POWER_W;
  localparam int WL = `IPM_WIN_LEN;
  localparam int SW = PW + `IPM_WIN_LOG2;
  localparam int AW = `IPM_ACC_W;
  localparam int TW = `IPM_TOTAL_W;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Instantaneous power of one complex sample
  function automatic logic [PW-1:0] ipm_power(input logic signed [SAMPLE_W-1:0] i,
                                               input logic signed [SAMPLE_W-1:0] q);
    logic signed [2*SAMPLE_W-1:0] pi;
    logic signed [2*SAMPLE_W-1:0] pq;
    pi = i * i;
    pq = q * q;
    ipm_power = PW'({1'b0, pi} + {1'b0, pq});
  endfunction : ipm_power

  // Window mean strictly above level, compared as sum > level * 8
  // Scaling the level by eight avoids a divider on the window sums
  function automatic logic ipm_above(input logic [SW-1:0] sum, input logic [PW-1:0] lvl);
    ipm_above = sum > {lvl, `IPM_WIN_LOG2'(0)};
  endfunction : ipm_above

  // ----------------------------------------------------------------------
  // Input stage and delay line
  // ----------------------------------------------------------------------
  logic [PW-1:0] pipe_reg [0:2*WL];
  logic [SW-1:0] sum_next_reg;
  logic [SW-1:0] sum_prev_reg;
  logic [4:0] fill_reg;
  logic take;
  logic [PW-1:0] p_new;
  logic [PW-1:0] p_mid;

  // Input freezes while the result buffer is full and a result is pending
  assign take = in_valid && in_ready && clk_en;
  assign p_new = ipm_power(in_i, in_q);
  assign p_mid = pipe_reg[WL]; // Sample under test, eight periods late [RULE_09]

  // Shift line of powers: [0..7] following window, [8] centre, [9..16] preceding
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k <= 2*WL; k++) begin
        pipe_reg[k] <= '0;
      end
    end else if (take) begin
      pipe_reg[0] <= p_new; // [RULE_03]
      for (int k = 1; k <= 2*WL; k++) begin
        pipe_reg[k] <= pipe_reg[k-1];
      end
    end
  end

  // Running sums of following and preceding eight powers [RULE_06]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sum_next_reg <= '0;
      sum_prev_reg <= '0;
    end else if (take) begin
      sum_next_reg <= sum_next_reg + SW'(p_new) - SW'(pipe_reg[WL-1]);
      sum_prev_reg <= sum_prev_reg + SW'(pipe_reg[WL]) - SW'(pipe_reg[2*WL]);
    end
  end

  // Window fill: no trigger decision until both windows hold real samples
  // Sums run on across restarts; only this count says the windows are fresh
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fill_reg <= '0;
    end else if (clk_en && !enable) begin
      fill_reg <= '0;
    end else if (take && fill_reg != 5'(2*WL + 1)) begin
      fill_reg <= fill_reg + 5'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Gating and accumulation
  // ----------------------------------------------------------------------
  ipm_state_t state_reg;
  logic [AW-1:0] acc_reg;
  logic [TW-1:0] total_reg;
  logic [TW-1:0] target;
  logic mid_ok;
  logic gate;
  logic accept;
  // Room in the result buffer, read by the sequencer ahead of the buffer logic
  logic buf_in_ready;

  // Centre sample valid once both windows are populated
  assign mid_ok = fill_reg == 5'(2*WL + 1);
  // Continuous passes all; triggered needs both means above level [RULE_04] [RULE_06] [RULE_08]
  assign gate = (mode == IPM_MODE_CONT) ||
                (ipm_above(sum_prev_reg, trig_level) && ipm_above(sum_next_reg, trig_level));
  assign accept = take && mid_ok && gate && state_reg == IPM_ST_ACC;
  // Target is blocks of 16 in continuous mode, samples in triggered mode [RULE_05] [RULE_07]
  // A mode change mid-measurement retargets at once; drop enable to restart
  assign target = (mode == IPM_MODE_CONT) ? TW'({avg_count, `IPM_BLOCK_LOG2'(0)})
                                          : TW'(avg_count);

  // Measurement sequencer; restarts after each result in either mode [RULE_02] [RULE_04]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= IPM_ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        IPM_ST_IDLE: begin
          if (enable && avg_count != '0) begin
            state_reg <= IPM_ST_ACC;
          end
        end
        IPM_ST_ACC: begin
          if (!enable) begin
            state_reg <= IPM_ST_IDLE;
          end else if (total_reg == target) begin
            state_reg <= IPM_ST_DIV;
          end
        end
        IPM_ST_DIV: begin
          if (buf_in_ready) begin
            state_reg <= enable ? IPM_ST_ACC : IPM_ST_IDLE;
          end
        end
        default: state_reg <= IPM_ST_IDLE;
      endcase
    end
  end

  // Sum of accepted powers and their count, cleared between results [RULE_05] [RULE_07]
  // Finished sums are held while the result waits for buffer room [RULE_09]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= '0;
      total_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == IPM_ST_IDLE || (state_reg == IPM_ST_DIV && buf_in_ready)) begin
        acc_reg <= '0;
        total_reg <= '0;
      end else if (accept && total_reg != target) begin
        acc_reg <= acc_reg + AW'(p_mid);
        total_reg <= total_reg + TW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result buffer, two entries
  // ----------------------------------------------------------------------
  logic [PW-1:0] buf_mem [0:`IPM_BUF_DEPTH-1];
  logic buf_wp_reg;
  logic buf_rp_reg;
  logic [1:0] buf_cnt_reg;
  logic buf_push;
  logic buf_pop;
  logic [PW-1:0] mean;

  // Mean power of the completed measurement [RULE_09]
  assign mean = PW'(acc_reg / AW'(total_reg));
  assign buf_in_ready = buf_cnt_reg != 2'(`IPM_BUF_DEPTH);
  assign buf_push = clk_en && state_reg == IPM_ST_DIV && buf_in_ready;
  assign buf_pop = clk_en && res_valid && res_ready;
  // Stall the stream only while a finished result cannot be stored
  assign in_ready = !(state_reg == IPM_ST_DIV && !buf_in_ready);
  assign res_valid = buf_cnt_reg != 2'd0;
  assign busy = state_reg != IPM_ST_IDLE;

  // Buffer storage and pointers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf_mem[0] <= `IPM_RESULT_RESET;
      buf_mem[1] <= `IPM_RESULT_RESET;
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
      buf_cnt_reg <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp_reg] <= mean;
        buf_wp_reg <= ~buf_wp_reg;
      end
      if (buf_pop) begin
        buf_rp_reg <= ~buf_rp_reg;
      end
      buf_cnt_reg <= buf_cnt_reg + 2'(buf_push) - 2'(buf_pop);
    end
  end

  assign res_power = buf_mem[buf_rp_reg];

  // One-cycle strobe for each new result [RULE_09]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      res_strobe <= 1'b0;
    end else if (clk_en) begin
      res_strobe <= buf_push;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // All checks run on the sample clock and sleep through reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Gating of samples into the accumulator
  cont_all_accept_a: assert property ( // [RULE_04]
    (take && mid_ok && state_reg == IPM_ST_ACC && mode == IPM_MODE_CONT
     && total_reg != target) |-> accept)
    else $error("continuous sample not accumulated");
  trig_gate_a: assert property ( // [RULE_06]
    (accept && mode == IPM_MODE_TRIG) |->
    (sum_prev_reg > {trig_level, 3'b000}) && (sum_next_reg > {trig_level, 3'b000}))
    else $error("triggered sample accepted below level");
  trig_reject_a: assert property ( // [RULE_08]
    (mode == IPM_MODE_TRIG && !(sum_next_reg > {trig_level, 3'b000})) |-> !accept)
    else $error("isolated sample accepted");
  acc_count_a: assert property ( // [RULE_07]
    (clk_en && accept && total_reg != target) |=> total_reg == $past(total_reg) + 1)
    else $error("accepted count not advanced");

  // Measurement totals and hand-over
  cont_target_a: assert property ( // [RULE_05]
    (state_reg == IPM_ST_DIV && mode == IPM_MODE_CONT) |->
    total_reg == TW'(avg_count) * TW'(`IPM_BLOCK_LEN))
    else $error("continuous total not count times 16");
  trig_target_a: assert property ( // [RULE_07]
    (state_reg == IPM_ST_DIV && mode == IPM_MODE_TRIG) |->
    total_reg == TW'(avg_count))
    else $error("triggered total not the averaging count");
  done_div_a: assert property ( // [RULE_02]
    (state_reg == IPM_ST_ACC && clk_en && enable && total_reg == target)
    |=> state_reg == IPM_ST_DIV)
    else $error("finished measurement not reported");
  div_hold_a: assert property ( // [RULE_09]
    (state_reg == IPM_ST_DIV && !buf_in_ready) |=>
    $stable(acc_reg) && $stable(total_reg))
    else $error("finished sums lost while waiting");

  // Result strobe, buffer and delay line
  strobe_pulse_a: assert property ( // [RULE_09]
    (res_strobe && clk_en) |=> !res_strobe)
    else $error("result strobe longer than one cycle");
  delay_tap_a: assert property ( // [RULE_09]
    take[*8] ##1 take |=> p_mid == $past(p_new, 9))
    else $error("centre tap not eight samples late");
  push_strobe_a: assert property ( // [RULE_09]
    buf_push |=> res_strobe && res_valid)
    else $error("pushed result not flagged");
  head_hold_a: assert property ( // [RULE_09]
    (res_valid && !buf_pop) |=> res_valid && $stable(res_power))
    else $error("unread result changed");

  // ----------------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------------
  cont_done_c: cover property (buf_push && mode == IPM_MODE_CONT);
  trig_done_c: cover property (buf_push && mode == IPM_MODE_TRIG);
  trig_reject_c: cover property (take && mid_ok && mode == IPM_MODE_TRIG && !gate);
  buf_full_c: cover property (buf_cnt_reg == 2'd2 && !res_ready);
  div_stall_c: cover property (state_reg == IPM_ST_DIV && !buf_in_ready);
endmodule : ipm_meter

// ==== hdl/ipm_params.svh ====
// Constants for the input power meter: widths, window sizes, reset values.
// Assumes inclusion by bare name from the meter package and top module.
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH
// ----------------------------------------------------------------------
// Stream and window
// ----------------------------------------------------------------------
`define IPM_SAMPLE_W 16
`define IPM_POWER_W 32
`define IPM_WIN_LEN 8
`define IPM_WIN_LOG2 3
`define IPM_BLOCK_LEN 16
`define IPM_BLOCK_LOG2 4
`define IPM_COUNT_W 16
`define IPM_ACC_W 56
`define IPM_TOTAL_W 24
`define IPM_SAMPLE_RATE_MHZ 78
`define IPM_RESULT_RESET 32'h0000_0000
`define IPM_BUF_DEPTH 2
`endif

// ==== hdl/ipm_pkg.sv ====
// Types shared by the input power meter.
// Assumes the constants header is on the include path.
`include "ipm_params.svh"
package ipm_pkg;
  // ----------------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------------
  typedef enum logic {IPM_MODE_CONT, IPM_MODE_TRIG} ipm_mode_t;
  typedef enum logic [1:0] {IPM_ST_IDLE, IPM_ST_ACC, IPM_ST_DIV} ipm_state_t;
endpackage : ipm_pkg

// ==== test/ipm_sample_src.sv ====
// Sample source model standing in front of the power meter input.
// Assumes the bench fills its queue through push and one ref_clk domain.
`timescale 1ns/1ps
`include "ipm_params.svh"
module ipm_sample_src (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic in_ready,
  output logic signed [`IPM_SAMPLE_W-1:0] in_i,
  output logic signed [`IPM_SAMPLE_W-1:0] in_q,
  output logic in_valid
);
  logic [2*`IPM_SAMPLE_W-1:0] fifo[$];

  // Queue one sample pair for sending
  task automatic push(input logic signed [`IPM_SAMPLE_W-1:0] i,
                      input logic signed [`IPM_SAMPLE_W-1:0] q);
    fifo.push_back({i, q});
  endtask : push

  // Hold each sample while in_ready is low, even with clk_en low; idle lines toggle so no stale value shows
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_valid <= 1'b0;
      in_i <= 16'h0000;
      in_q <= 16'h0000;
    end else if (!in_valid || in_ready) begin
      if (fifo.size() > 0) begin
        {in_i, in_q} <= fifo.pop_front();
        in_valid <= 1'b1;
      end else begin
        in_valid <= 1'b0;
        in_i <= ~in_i;
        in_q <= ~in_q;
      end
    end
  end
endmodule : ipm_sample_src

// ==== test/ipm_meter_tb.sv ====
// Self-checking bench for the power meter: reset, both modes, result stall.
// Assumes the meter package, constants header and sample source model.
`timescale 1ns/1ps
`include "ipm_params.svh"
module ipm_meter_tb;
  import ipm_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  ipm_mode_t mode = IPM_MODE_CONT;
  logic enable = 1'b0;
  logic [15:0] avg_count = 16'h0000;
  logic [31:0] trig_level = 32'h0000_0000;
  logic signed [`IPM_SAMPLE_W-1:0] in_i;
  logic signed [`IPM_SAMPLE_W-1:0] in_q;
  logic in_valid, in_ready, res_valid, res_strobe, busy;
  logic res_ready = 1'b1;
  logic [31:0] res_power;
  int bad_count = 0;
  int compares = 0;
  int takes = 0;
  int strobe_at[$];
  logic [31:0] got_q[$];

  // ----------------------------------------------------------------------
  // Clock, parts and monitor
  // ----------------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  ipm_meter dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .mode(mode),
    .enable(enable), .avg_count(avg_count), .trig_level(trig_level), .in_i(in_i),
    .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready), .res_power(res_power),
    .res_valid(res_valid), .res_ready(res_ready), .res_strobe(res_strobe), .busy(busy));
  ipm_sample_src src_u (.ref_clk(ref_clk), .rstn(rstn), .in_ready(in_ready),
    .in_i(in_i), .in_q(in_q), .in_valid(in_valid));

  // Count takes, note strobe positions and popped results
  always @(posedge ref_clk) begin
    if (clk_en === 1'b1 && in_valid === 1'b1 && in_ready === 1'b1) takes <= takes + 1;
    if (res_strobe === 1'b1) strobe_at.push_back(takes);
    if (clk_en === 1'b1 && res_valid === 1'b1 && res_ready === 1'b1)
      got_q.push_back(res_power);
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic restart(input ipm_mode_t m, input int c, input logic [31:0] lvl,
                         input logic rdy);
    @(posedge ref_clk);
    enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("idle busy", 1'b0, busy);
    mode <= m;
    avg_count <= c[15:0];
    trig_level <= lvl;
    res_ready <= rdy;
    enable <= 1'b1;
    @(negedge ref_clk);
    got_q.delete();
    strobe_at.delete();
  endtask : restart

  task automatic feed(input int n, input int i, input int q);
    for (int k = 0; k < n; k++) src_u.push(i[15:0], q[15:0]);
  endtask : feed

  task automatic settle();
    int n;
    n = 0;
    while ((src_u.fifo.size() != 0 || in_valid === 1'b1) && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (40) @(negedge ref_clk);
  endtask : settle

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    check("reset valid", 1'b0, res_valid);
    check("reset strobe", 1'b0, res_strobe);
    check("reset power", 32'h0000_0000, res_power);
    check("reset ready", 1'b1, in_ready);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_cont();
    int d;
    for (int c = 1; c <= 2; c++) begin
      restart(IPM_MODE_CONT, c, 32'h0000_0000, 1'b1);
      feed(90, 3, 4);
      settle();
      check("cont results", 1'b1, got_q.size() >= 2);
      check("strobes", got_q.size(), strobe_at.size());
      foreach (got_q[k]) check("cont mean", 32'h0000_0019, got_q[k]);
      check("first block", 1'b1, strobe_at[0] >= 16 * c);
      for (int k = 1; k < strobe_at.size(); k++) begin
        d = strobe_at[k] - strobe_at[k-1];
        check("block gap", 1'b1, d >= 16 * c && d <= 16 * c + 2);
      end
    end
    $display("test_cont done");
  endtask : test_cont

  task automatic test_trig();
    restart(IPM_MODE_TRIG, 20, 32'h0000_0064, 1'b1);
    feed(12, 1, 0);
    feed(1, 100, 0);
    feed(20, 1, 0);
    feed(16, 20, 0);
    feed(20, 1, 0);
    feed(16, 20, 0);
    feed(20, 1, 0);
    settle();
    check("trig results", 1, got_q.size());
    check("trig mean", 32'h0000_0190, got_q[0]);
    check("across gap", 1'b1, strobe_at[0] > 69);
    $display("test_trig done");
  endtask : test_trig

  task automatic test_stall();
    int n;
    restart(IPM_MODE_CONT, 1, 32'h0000_0000, 1'b0);
    feed(100, 3, 4);
    n = 0;
    while (in_ready !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (20) @(negedge ref_clk);
    check("stall ready", 1'b0, in_ready);
    check("stall hold", 1'b1, in_valid);
    check("stall head", 32'h0000_0019, res_power);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    res_ready <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check("frozen pops", 0, got_q.size());
    check("frozen head", 1'b1, res_valid);
    check("frozen ready", 1'b0, in_ready);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    settle();
    check("drained", 1'b0, res_valid);
    check("no loss", 1'b1, got_q.size() >= 4);
    foreach (got_q[k]) check("stall mean", 32'h0000_0019, got_q[k]);
    $display("test_stall done");
  endtask : test_stall

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    test_reset();
    test_cont();
    test_trig();
    test_stall();
    print_verdict();
  end

  // Watchdog far beyond the expected run length
  initial begin
    #(20000 * 100);
    bad_count++;
    print_verdict();
  end
endmodule : ipm_meter_tb
